// [hw/hssw_pkg.sv]
// shared constants, types and helpers of the high-side switch control
package hssw_pkg;
  localparam int CLK_MHZ = 20;
  localparam int NCH = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SRC_W = 4;
  localparam int CTRL_W = NCH * SRC_W;
  localparam int PWM_W = 10;
  localparam int TMR_W = 16;
  localparam int GEN_N = 6;
  localparam int ANA_W = 11;
  localparam int STS_W = 10;
  localparam int WAKE_W = 2;

  // filter and tick times in microseconds, counts derived from the clock
  localparam int OC_FILT_US = 16;
  localparam int OC_FILT_CYC = OC_FILT_US * CLK_MHZ;
  localparam int OL_FILT_US = 220;
  localparam int OL_FILT_CYC_DEF = OL_FILT_US * CLK_MHZ;
  localparam int TMR_TICK_US = 1000;
  localparam int TMR_TICK_CYC_DEF = TMR_TICK_US * CLK_MHZ;
  localparam int PWM_SLOW_DIV = 4;
  localparam int OC_CNT_W = 9;
  localparam int OL_CNT_W = 13;
  localparam int TICK_W = 15;
  localparam logic [OC_CNT_W-1:0] OC_LIMIT = OC_CNT_W'(OC_FILT_CYC);
  localparam logic [PWM_W-1:0] PWM_PERIOD = 10'h3FF;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] A_TMR1 = 8'h08;
  localparam logic [ADDR_W-1:0] A_TMR2 = 8'h0C;
  localparam logic [ADDR_W-1:0] A_PWM1 = 8'h10;
  localparam logic [ADDR_W-1:0] A_STEP = 8'h04;
  localparam logic [ADDR_W-1:0] A_STS = 8'h20;
  localparam logic [ADDR_W-1:0] A_WAKE = 8'h24;

  // status field positions
  localparam int STS_OC_LSB = 0;
  localparam int STS_OL_LSB = 4;
  localparam int STS_UV_BIT = 8;
  localparam int STS_OV_BIT = 9;

  // generator vector positions
  localparam int GEN_TMR1 = 0;
  localparam int GEN_TMR2 = 1;
  localparam int GEN_PWM1 = 2;
  localparam int GEN_PWM2 = 3;
  localparam int GEN_PWM3 = 4;
  localparam int GEN_PWM4 = 5;

  typedef enum logic [SRC_W-1:0] {
    SRC_OFF = 4'h0, SRC_ON = 4'h1, SRC_TMR1 = 4'h2, SRC_TMR2 = 4'h3,
    SRC_PWM1 = 4'h4, SRC_PWM2 = 4'h5, SRC_PWM3 = 4'h6, SRC_PWM4 = 4'h7,
    SRC_SYNC = 4'h8
  } hssw_src_t;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_STOP = 3'h1, MODE_SLEEP = 3'h3,
    MODE_RESTART = 3'h2, MODE_FAILSAFE = 3'h6
  } hssw_mode_t;

  localparam logic [WAKE_W-1:0] WAKE_OFF = 2'h0;
  localparam logic [WAKE_W-1:0] WAKE_WAKE = 2'h1;
  localparam logic [WAKE_W-1:0] WAKE_SYNC = 2'h2;

  typedef struct packed {
    logic [NCH-1:0] ov_rec;
    logic glb_ov_dis;
    logic [NCH-1:0] ov_dis;
    logic uv_rec;
    logic uv_dis;
  } hssw_cfg_t;

  typedef struct packed {
    logic [TMR_W-1:0] duty;
    logic [TMR_W-1:0] period;
  } hssw_tmr_t;

  typedef struct packed {
    logic freq_slow;
    logic [PWM_W-1:0] duty;
  } hssw_pwm_t;

  typedef struct packed {
    logic wake4;
    logic [NCH-1:0] ol;
    logic [NCH-1:0] oc;
    logic ov;
    logic uv;
  } hssw_ana_t;

  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam hssw_cfg_t CFG_RST = 11'h000;
  localparam hssw_tmr_t TMR_RST = 32'h0000_0000;
  localparam hssw_pwm_t PWM_RST = 11'h000;

  function automatic logic src_bit(input logic [SRC_W-1:0] code,
                                   input logic [GEN_N-1:0] gen,
                                   input logic sync);
    logic r;
    r = 1'b0;
    case (code)
      SRC_ON: r = 1'b1;
      SRC_TMR1: r = gen[GEN_TMR1];
      SRC_TMR2: r = gen[GEN_TMR2];
      SRC_PWM1: r = gen[GEN_PWM1];
      SRC_PWM2: r = gen[GEN_PWM2];
      SRC_PWM3: r = gen[GEN_PWM3];
      SRC_PWM4: r = gen[GEN_PWM4];
      SRC_SYNC: r = sync;
      default: r = 1'b0;
    endcase
    return r;
  endfunction
endpackage

// [hw/hssw_gen.sv]
// period and duty generator shared by the timers and pwm generators
`timescale 1ns/10ps
`default_nettype none
module hssw_gen
  import hssw_pkg::*;
#(
  parameter int W = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // setting
  input wire logic tick,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  // waveform
  output logic on_q
);
  logic [W-1:0] cnt_q;
  wire wrap = (cnt_q == period - W'(1)) || (period == {W{1'b0}});

  // very short on-times are still generated; the switch edges eat them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {W{1'b0}};
      on_q <= 1'b0;
    end else begin
      if (tick) begin
        cnt_q <= wrap ? {W{1'b0}} : cnt_q + W'(1);
      end
      on_q <= cnt_q < duty;
    end
  end
endmodule
`default_nettype wire

// [hw/hssw_top.sv]
// high-side switch control: apb registers, sources and protection
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module hssw_top
  import hssw_pkg::*;
#(
  parameter int OL_FILT_CYC = OL_FILT_CYC_DEF,
  parameter int TMR_TICK_CYC = TMR_TICK_CYC_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // device mode from mode control
  input wire hssw_mode_t device_mode,
  // comparator levels and wake pin, asynchronous
  input wire hssw_ana_t ana_async,
  // switch drive and wake pin capability
  output logic [NCH-1:0] load_switch_output,
  output logic wake_pin_four_wake_en
);
  localparam logic [OL_CNT_W-1:0] OL_LIMIT = OL_CNT_W'(OL_FILT_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TMR_TICK_CYC - 1);
  localparam logic [2:0] SLOW_LAST = 3'(PWM_SLOW_DIV - 1);

  logic [ANA_W-1:0] ana_meta_q;
  logic [ANA_W-1:0] ana_sync_q;
  hssw_ana_t ana_s;
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  hssw_cfg_t cfg_q;
  hssw_tmr_t tmr1_q;
  hssw_tmr_t tmr2_q;
  hssw_pwm_t pwm_q [NCH];
  logic [WAKE_W-1:0] wake_sel_q;
  logic [STS_W-1:0] sts_q;
  logic [NCH-1:0] drive_q;
  logic [NCH-1:0] drive_d;
  logic [NCH-1:0] uv_shut_q;
  logic [NCH-1:0] uv_shut_d;
  logic [NCH-1:0] ov_shut_q;
  logic [NCH-1:0] ov_shut_d;
  logic [NCH-1:0] oc_trip;
  logic [NCH-1:0] ol_set;
  logic [NCH-1:0] uv_clr;
  logic [NCH-1:0] ov_clr;
  logic [NCH-1:0] ov_kill;
  logic [NCH-1:0] hit_pwm;
  logic [NCH-1:0] pwm_on;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [2:0] slow_cnt_q;
  logic tmr1_on;
  logic tmr2_on;
  logic [DATA_W-1:0] rd_pwm;

  // comparator levels: two flops before anything looks at them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ana_meta_q <= 11'h000;
      ana_sync_q <= 11'h000;
    end else begin
      ana_meta_q <= ana_async;
      ana_sync_q <= ana_meta_q;
    end
  end
  assign ana_s = hssw_ana_t'(ana_sync_q);

  // mode decode
  wire normal_mode = device_mode == MODE_NORMAL;
  wire lowpower = (device_mode == MODE_STOP) || (device_mode == MODE_SLEEP);
  wire kill_all = (device_mode == MODE_RESTART) ||
                  (device_mode == MODE_FAILSAFE);

  // apb decode; one wait state, then the access completes
  wire hit_ctrl = paddr == A_CTRL;
  wire hit_cfg = paddr == A_CFG;
  wire hit_tmr1 = paddr == A_TMR1;
  wire hit_tmr2 = paddr == A_TMR2;
  wire hit_sts = paddr == A_STS;
  wire hit_wake = paddr == A_WAKE;
  for (genvar g = 0; g < NCH; g++) begin : g_hit
    assign hit_pwm[g] = paddr == ADDR_W'(A_PWM1 + A_STEP * g);
  end
  wire mapped = hit_ctrl | hit_cfg | hit_tmr1 | hit_tmr2 | hit_sts |
                hit_wake | (|hit_pwm);
  // settings are frozen in stop and sleep mode; status stays clearable
  wire lp_block = pwrite && lowpower && !hit_sts;
  wire acc_err = !mapped || lp_block;
  wire pready_d = psel && penable && !pready;
  wire commit = psel && penable && pready;
  wire wr_ok = commit && pwrite && !acc_err;
  wire wr_ctrl = wr_ok && hit_ctrl;
  wire wr_sts = wr_ok && hit_sts;

  always_comb begin
    rd_pwm = 32'h0000_0000;
    for (int k = 0; k < NCH; k++) begin
      if (hit_pwm[k]) begin
        rd_pwm = DATA_W'(pwm_q[k]);
      end
    end
  end
  wire [DATA_W-1:0] rdata = !mapped ? 32'h0000_0000 :
                            hit_ctrl ? DATA_W'(ctrl_q) :
                            hit_cfg ? DATA_W'(cfg_q) :
                            hit_tmr1 ? DATA_W'(tmr1_q) :
                            hit_tmr2 ? DATA_W'(tmr2_q) :
                            hit_sts ? DATA_W'(sts_q) :
                            hit_wake ? DATA_W'(wake_sel_q) : rd_pwm;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= pready_d;
      pslverr <= pready_d && acc_err;
      if (pready_d) begin
        prdata <= rdata;
      end
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
      tmr1_q <= TMR_RST;
      tmr2_q <= TMR_RST;
      wake_sel_q <= WAKE_OFF;
      for (int k = 0; k < NCH; k++) begin
        pwm_q[k] <= PWM_RST;
      end
    end else begin
      if (wr_ok && hit_cfg) begin
        cfg_q <= hssw_cfg_t'(pwdata[$bits(hssw_cfg_t)-1:0]);
      end
      if (wr_ok && hit_tmr1) begin
        tmr1_q <= hssw_tmr_t'(pwdata);
      end
      if (wr_ok && hit_tmr2) begin
        tmr2_q <= hssw_tmr_t'(pwdata);
      end
      if (wr_ok && hit_wake) begin
        wake_sel_q <= pwdata[WAKE_W-1:0];
      end
      for (int k = 0; k < NCH; k++) begin
        if (wr_ok && hit_pwm[k]) begin
          pwm_q[k] <= hssw_pwm_t'(pwdata[$bits(hssw_pwm_t)-1:0]);
        end
      end
    end
  end

  // shared prescalers: timer tick and slow pwm rate
  wire tmr_tick = tick_cnt_q == TICK_LAST;
  wire slow_tick = slow_cnt_q == SLOW_LAST;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 15'h0000;
      slow_cnt_q <= 3'h0;
    end else begin
      tick_cnt_q <= tmr_tick ? 15'h0000 : tick_cnt_q + 15'h0001;
      slow_cnt_q <= slow_tick ? 3'h0 : slow_cnt_q + 3'h1;
    end
  end

  // two timers, each with its own period and duty
  hssw_gen #(.W(TMR_W)) u_tmr1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tmr_tick),
    .period(tmr1_q.period),
    .duty(tmr1_q.duty),
    .on_q(tmr1_on)
  );
  hssw_gen #(.W(TMR_W)) u_tmr2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tmr_tick),
    .period(tmr2_q.period),
    .duty(tmr2_q.duty),
    .on_q(tmr2_on)
  );
  // pwm generators free-run, so an assignment takes effect at once
  for (genvar g = 0; g < NCH; g++) begin : g_pwm
    wire pwm_tick = pwm_q[g].freq_slow ? slow_tick : 1'b1;
    hssw_gen #(.W(PWM_W)) u_pwm (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(pwm_tick),
      .period(PWM_PERIOD),
      .duty(pwm_q[g].duty),
      .on_q(pwm_on[g])
    );
  end

  // sync from wake pin four only when that pin is switched to sync use
  wire sync_sel = wake_sel_q == WAKE_SYNC;
  wire sync_in = ana_s.wake4 && sync_sel;
  wire [GEN_N-1:0] gen_v = {pwm_on, tmr2_on, tmr1_on};
  wire uv_kill = ana_s.uv && !cfg_q.uv_dis;

  // per-channel source, protection and filters
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [OC_CNT_W-1:0] oc_cnt_q;
    logic [OL_CNT_W-1:0] ol_cnt_q;
    wire [SRC_W-1:0] code = ctrl_q[g*SRC_W +: SRC_W];
    // static codes hold in any mode that is not restart or fail-safe
    wire src_on = src_bit(code, gen_v, sync_in);
    wire cfg_on = code != SRC_OFF;
    wire oc_hot = drive_q[g] && ana_s.oc[g];
    wire ol_hot = drive_q[g] && ana_s.ol[g];
    assign ov_kill[g] = ana_s.ov &&
      (normal_mode ? !cfg_q.ov_dis[g] :
       (lowpower && !cfg_q.glb_ov_dis));
    assign oc_trip[g] = oc_hot && (oc_cnt_q == OC_LIMIT);
    assign ol_set[g] = ol_hot && (ol_cnt_q == OL_LIMIT);
    assign drive_d[g] = src_on && !kill_all && !uv_kill &&
                        !ov_kill[g] && !oc_trip[g];
    // shutdown memory tells which channels must be cleared on release
    assign uv_shut_d[g] = ana_s.uv && (uv_shut_q[g] || (uv_kill && cfg_on));
    assign ov_shut_d[g] = ana_s.ov && (ov_shut_q[g] || (ov_kill[g] && cfg_on));
    assign uv_clr[g] = uv_shut_q[g] && !ana_s.uv && !cfg_q.uv_rec;
    assign ov_clr[g] = ov_shut_q[g] && !ana_s.ov &&
                       !cfg_q.ov_rec[g];
    // hardware clears win over a software write in the same cycle
    assign ctrl_d[g*SRC_W +: SRC_W] =
      (oc_trip[g] || uv_clr[g] || ov_clr[g]) ? SRC_OFF :
      wr_ctrl ? pwdata[g*SRC_W +: SRC_W] : code;

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        oc_cnt_q <= 9'h000;
        ol_cnt_q <= 13'h0000;
      end else begin
        // filters restart whenever the output or condition drops
        if (!oc_hot) begin
          oc_cnt_q <= 9'h000;
        end else if (oc_cnt_q != OC_LIMIT) begin
          oc_cnt_q <= oc_cnt_q + 9'h001;
        end
        if (!ol_hot) begin
          ol_cnt_q <= 13'h0000;
        end else if (ol_cnt_q != OL_LIMIT) begin
          ol_cnt_q <= ol_cnt_q + 13'h0001;
        end
      end
    end
  end

  // status: write one to clear, a new event wins over the clear
  wire [STS_W-1:0] sts_set =
    {ana_s.ov, ana_s.uv, ol_set, oc_trip};
  wire [STS_W-1:0] clr_req = wr_sts ? pwdata[STS_W-1:0] : 10'h000;
  // open-load bits only clear once the condition has gone
  wire [STS_W-1:0] ol_hold = {2'h0, ana_s.ol, 4'h0};
  wire [STS_W-1:0] clr_eff = clr_req & ~ol_hold;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      sts_q <= 10'h000;
      drive_q <= 4'h0;
      uv_shut_q <= 4'h0;
      ov_shut_q <= 4'h0;
      wake_pin_four_wake_en <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      sts_q <= (sts_q & ~clr_eff) | sts_set;
      drive_q <= drive_d;
      uv_shut_q <= uv_shut_d;
      ov_shut_q <= ov_shut_d;
      wake_pin_four_wake_en <= wake_sel_q == WAKE_WAKE;
    end
  end
  assign load_switch_output = drive_q;

  // checks
  sequence s_lp_write;
    psel && penable && pready && lp_block;
  endsequence

  a_uv_outputs_off: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (ana_s.uv && !cfg_q.uv_dis) |=> load_switch_output == 4'h0)
    else $error("outputs on during undervoltage shutdown");
  a_uv_flag_only: assert property (@(posedge mclk)
    disable iff (!rst_b)
    $rose(ana_s.uv) |=> sts_q[STS_UV_BIT] &&
      (sts_q[STS_OC_LSB +: NCH] == $past(sts_q[STS_OC_LSB +: NCH]) ||
       $past(|oc_trip || wr_sts)))
    else $error("undervoltage flag wrong");
  a_ov_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
    ana_s.ov |=> sts_q[STS_OV_BIT])
    else $error("overvoltage flag not set");
  a_ov_normal_off: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (normal_mode && ana_s.ov) |=>
      (load_switch_output & ~$past(cfg_q.ov_dis)) == 4'h0)
    else $error("output on during overvoltage");
  a_ov_lp_off: assert property (@(posedge mclk) disable iff (!rst_b)
    (lowpower && ana_s.ov && !cfg_q.glb_ov_dis) |=>
      load_switch_output == 4'h0)
    else $error("low-power overvoltage did not switch off");
  a_oc_trip_off: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (|oc_trip) |=>
      ((sts_q[STS_OC_LSB +: NCH] & $past(oc_trip)) == $past(oc_trip)) &&
      ((load_switch_output & $past(oc_trip)) == 4'h0) ##1
      ((load_switch_output & $past(oc_trip, 2)) == 4'h0))
    else $error("overcurrent trip not handled");
  a_oc_flag_sticky: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (sts_q[STS_OC_LSB +: NCH] != 4'h0 && !wr_sts) |=>
      (sts_q[STS_OC_LSB +: NCH] & $past(sts_q[STS_OC_LSB +: NCH])) ==
       $past(sts_q[STS_OC_LSB +: NCH]))
    else $error("overcurrent flag lost");
  a_ol_flag_on: assert property (@(posedge mclk) disable iff (!rst_b)
    (|ol_set) |=> (sts_q[STS_OL_LSB +: NCH] & $past(ol_set)) == $past(ol_set))
    else $error("open-load flag not set");
  a_mode_all_off: assert property (@(posedge mclk)
    disable iff (!rst_b)
    kill_all |=> load_switch_output == 4'h0)
    else $error("outputs on in restart or fail-safe");
  a_lp_reject: assert property (@(posedge mclk) disable iff (!rst_b)
    s_lp_write |-> pslverr ##1
      (ctrl_q == $past(ctrl_q) || $past(|(oc_trip | uv_clr | ov_clr))))
    else $error("configuration changed in low-power mode");
endmodule
`default_nettype wire

// [test/hssw_load_model.sv]
// load and supply model that drives the comparator levels
`timescale 1ns/10ps
`default_nettype none
module hssw_load_model
  import hssw_pkg::*;
(
  // switch side
  input wire logic [NCH-1:0] sw,
  // fault selection from the bench
  input wire logic [NCH-1:0] short_mask,
  input wire logic [NCH-1:0] open_mask,
  input wire logic uv,
  input wire logic ov,
  input wire logic wake4,
  // comparator levels
  output var hssw_ana_t ana
);
  // an off switch carries no current, so it reads as low current too
  assign ana.ol = open_mask | ~sw;
  assign ana.oc = short_mask & sw;
  assign ana.uv = uv;
  assign ana.ov = ov;
  assign ana.wake4 = wake4;
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the high-side switch control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hssw_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
  localparam int OLC = 40;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, wake_pin_function_select, err;
  hssw_mode_t mode = MODE_NORMAL;
  hssw_ana_t ana;
  logic [NCH-1:0] sw;
  logic [NCH-1:0] shrt = '0;
  logic [NCH-1:0] opn = '0;
  logic uv = 1'h0;
  logic ov = 1'h0;
  logic wk4 = 1'h0;
  logic [31:0] rd;
  logic [31:0] seed = 32'h7133;
  logic [9:0] d;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int m_ctrl = 0;
  int cnt;

  always #25 mclk = ~mclk;

  hssw_top #(.OL_FILT_CYC(OLC), .TMR_TICK_CYC(4)) dut (.mclk(mclk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_mode(mode), .ana_async(ana),
    .load_switch_output(sw), .wake_pin_four_wake_en(wake_pin_function_select));
  hssw_load_model load (.sw(sw), .short_mask(shrt), .open_mask(opn),
    .uv(uv), .ov(ov), .wake4(wk4), .ana(ana));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // static codes only: 1 is on, anything else here is off
  function automatic logic [NCH-1:0] exp_sw();
    logic [NCH-1:0] r;
    for (int i = 0; i < NCH; i++) r[i] = ((m_ctrl >> (4 * i)) & 15) == 1;
    return r;
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // waits for pready as long as it takes; only the bench timeout ends a hang
  task automatic apb(input logic wrt, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'h1, a, dat);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, '0);
    `CHK(rd, e)
  endtask

  task automatic setc(input int c);
    m_ctrl = c;
    wr(A_CTRL, 32'(c));
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic sup(input logic u, input logic o);
    uv <= u;
    ov <= o;
    w(5);
  endtask

  task automatic cntw(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge mclk);
      cnt += int'(sw[0]);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    rchk(A_CTRL, 32'h0);
    rchk(A_CFG, 32'h0);
    rchk(A_STS, 32'h0);
    apb(1'h0, 8'h30, '0);
    `CHK(err, 1'h1)
    done("reset");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      setc(seed & 32'h1111);
      w(4);
      `CHK(sw, exp_sw())
    end
    for (int t = 0; t < 2; t++) begin
      wr(A_TMR1 + 8'(4 * t), {16'(2 + 2 * t), 16'h8});
      setc(2 + t);
      w(2);
      cntw(720);
      `CHK(cnt >= 160 * t + 150 && cnt <= 180 * t + 190, 1'h1)
    end
    for (int g = 0; g < 4; g++) begin
      seed = lfsr(seed);
      d = seed[9:0];
      wr(A_PWM1 + 8'(4 * g), {21'h0, g == 3, d});
      setc(4 + g);
      w(2);
      cntw(g == 3 ? 4092 : 1023);
      cnt -= (g == 3) ? 4 * d : d;
      `CHK(cnt > -10 && cnt < 10, 1'h1)
    end
    done("sources");
    setc(32'h1111);
    sup(1'h1, 1'h0);
    `CHK(sw, 4'h0)
    rchk(A_STS, 32'h100);
    sup(1'h0, 1'h0);
    `CHK(sw, 4'h0)
    rchk(A_CTRL, 32'h0);
    wr(A_STS, 32'h3FF);
    setc(32'h0101);
    wr(A_CFG, 32'h2);
    sup(1'h1, 1'h0);
    `CHK(sw, 4'h0)
    sup(1'h0, 1'h0);
    `CHK(sw, 4'h5)
    wr(A_CFG, 32'h1);
    sup(1'h1, 1'h0);
    `CHK(sw, 4'h5)
    sup(1'h0, 1'h0);
    wr(A_STS, 32'h3FF);
    done("undervoltage");
    wr(A_CFG, 32'h104);
    setc(32'h1111);
    sup(1'h0, 1'h1);
    `CHK(sw, 4'h1)
    rchk(A_STS, 32'h200);
    sup(1'h0, 1'h0);
    `CHK(sw, 4'h3)
    rchk(A_CTRL, 32'h0011);
    wr(A_STS, 32'h3FF);
    wr(A_CFG, 32'h40);
    setc(32'h1111);
    mode <= MODE_STOP;
    w(2);
    wr(A_CTRL, 32'h0);
    `CHK(err, 1'h1)
    `CHK(sw, 4'hF)
    sup(1'h0, 1'h1);
    `CHK(sw, 4'hF)
    sup(1'h0, 1'h0);
    mode <= MODE_NORMAL;
    wr(A_STS, 32'h3FF);
    wr(A_CFG, 32'h780);
    mode <= MODE_SLEEP;
    sup(1'h0, 1'h1);
    `CHK(sw, 4'h0)
    rchk(A_STS, 32'h200);
    sup(1'h0, 1'h0);
    `CHK(sw, 4'hF)
    mode <= MODE_NORMAL;
    wr(A_STS, 32'h3FF);
    done("overvoltage");
    mode <= MODE_RESTART;
    w(3);
    `CHK(sw, 4'h0)
    mode <= MODE_FAILSAFE;
    w(3);
    `CHK(sw, 4'h0)
    mode <= MODE_NORMAL;
    w(3);
    `CHK(sw, 4'hF)
    done("modes");
    setc(32'h0100);
    shrt <= 4'h4;
    w(300);
    `CHK(sw, 4'h4)
    w(40);
    `CHK(sw, 4'h0)
    rchk(A_STS, 32'h4);
    rchk(A_CTRL, 32'h0);
    shrt <= 4'h0;
    w(20);
    rchk(A_STS, 32'h4);
    wr(A_STS, 32'h4);
    rchk(A_STS, 32'h0);
    setc(32'h0100);
    w(5);
    `CHK(sw, 4'h4)
    done("overcurrent");
    setc(32'h1000);
    opn <= 4'h8;
    w(OLC + 20);
    `CHK(sw, 4'h8)
    rchk(A_STS, 32'h80);
    wr(A_STS, 32'h80);
    rchk(A_STS, 32'h80);
    opn <= 4'h0;
    w(5);
    wr(A_STS, 32'h80);
    rchk(A_STS, 32'h0);
    done("open load");
    wr(A_WAKE, 32'h1);
    w(2);
    `CHK(wake_pin_function_select, 1'h1)
    wr(A_WAKE, 32'h2);
    w(2);
    `CHK(wake_pin_function_select, 1'h0)
    setc(32'h8);
    wk4 <= 1'h1;
    w(5);
    `CHK(sw, 4'h1)
    wk4 <= 1'h0;
    w(5);
    `CHK(sw, 4'h0)
    done("sync");
    report_and_stop();
  end
endmodule
`default_nettype wire
